//--- hdl/prs_cfg.svh
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH
// APB byte addresses of the unit registers
`define PRS_ADDR_RELOAD_CONTROL     12'h000
`define PRS_ADDR_SLAVE_SYNC_CONTROL 12'h004
`define PRS_ADDR_START_DELAY_HIGH   12'h008
`define PRS_ADDR_START_DELAY_LOW    12'h00C
`define PRS_ADDR_ACTIVE_WIDTH_HIGH  12'h010
`define PRS_ADDR_ACTIVE_WIDTH_LOW   12'h014
`define PRS_ADDR_CYCLE_LENGTH_HIGH  12'h018
`define PRS_ADDR_CYCLE_LENGTH_LOW   12'h01C
`define PRS_ADDR_SLAVE_TRIG_HIGH    12'h020
`define PRS_ADDR_SLAVE_TRIG_LOW     12'h024
`define PRS_ADDR_UNIT_MODE          12'h028
`define PRS_ADDR_COUNTER_STATUS     12'h02C
// Field positions
`define PRS_RELOAD_ARMED_BIT        7
`define PRS_RELOAD_BY_TRIGGER_BIT   6
`define PRS_SLAVE_RUN_LSB           5
`define PRS_MATCH_DIRECTION_BIT     4
// Reset values of the control registers and operating buffers, and control write masks
`define PRS_RELOAD_CONTROL_RESET    8'h00
`define PRS_SLAVE_SYNC_RESET        8'h00
`define PRS_UNIT_MODE_RESET         8'h00
`define PRS_OPERATING_RESET         16'h0000
`define PRS_RELOAD_CONTROL_MASK     8'hC3
`define PRS_SLAVE_SYNC_MASK         8'h73
`endif

//--- hdl/prs_pkg.sv
package prs_pkg;
  typedef enum logic [1:0] {
    PRS_MODE_STANDARD = 2'b00,
    PRS_MODE_SET      = 2'b01,
    PRS_MODE_TOGGLE   = 2'b10,
    PRS_MODE_CENTER   = 2'b11
  } prs_align_t;
  typedef enum logic [1:0] {
    PRS_RUN_INDEPENDENT = 2'b00,
    PRS_RUN_SYNC_START  = 2'b01,
    PRS_RUN_ONE_SHOT    = 2'b10,
    PRS_RUN_CONTINUOUS  = 2'b11
  } prs_slave_run_t;
  // Gray coded along idle -> waiting -> running -> done
  typedef enum logic [1:0] {
    PRS_ST_IDLE    = 2'b00,
    PRS_ST_WAIT    = 2'b01,
    PRS_ST_RUN     = 2'b11,
    PRS_ST_DONE    = 2'b10
  } prs_state_t;
endpackage : prs_pkg

//--- hdl/prs_trigger_select.sv
`timescale 1ns/1ps
`default_nettype none
// Picks one sibling event by a two-bit source code; code 00 and own unit yield nothing
module prs_trigger_select (
  input  wire logic [2:0] events,
  input  wire logic [1:0] sourceSel,
  input  wire logic [1:0] ownIndex,
  output logic            picked
);
  logic [3:0] hit;
  genvar gi;
  generate
    for (gi = 1; gi < 4; gi++) begin : g_src
      assign hit[gi] = (sourceSel == 2'(gi)) && (ownIndex != 2'(gi)) && events[gi-1];
    end
  endgenerate
  assign hit[0] = 1'b0;
  assign picked = |hit;
endmodule : prs_trigger_select
`default_nettype wire

//--- hdl/prs_unit.sv
// Overview of operation
// - With trigger reload and armed, buffers load at period end after sibling load event.
// - Trigger reload clear: armed bit reloads buffers at current period end, source ignored.
// - Reload source 11/10/01 pick unit three/two/one load event; 00 reserved.
// - Reload source naming the unit itself is reserved and never triggers.
// - Hardware clears armed bit after reload; software may clear it to cancel.
// - Slave run 00 runs free; 01 starts counting on selected offset trigger.
// - Slave run 10 runs a single period started by the offset trigger.
// - Slave run 11 resets counter and restarts on every offset trigger.
// - Center mode: match direction 1 fires on down-count match, 0 on up-count.
// - Other modes ignore match direction for the offset match event.
// - Slave source 11/10/01 pick unit three/two/one match; 00 and own reserved.
// - Phase value is 16 bits in high and low readable writable bytes.
// - Duty value is 16 bits in high and low byte registers.
// - Period value is 16 bits in high and low byte registers.
// - Offset high byte register is readable and writable.
// - Value bytes have no reset; they keep contents across resets.
// - Unimplemented control bits read zero and ignore writes.
// - Value writes take effect only at a reload, all together.
// - Arming in the cycle counter equals period waits for the next period event.
// - Match direction is double buffered and moves only at a reload.
`timescale 1ns/1ps
`default_nettype none
`include "prs_cfg.svh"
module prs_unit #(
  parameter logic [1:0] OWN_INDEX = 2'd1
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  siblingLoadEvent,
  input  wire logic [2:0]  siblingCompareEvent,
  output logic [15:0]      waveformCounter,
  output logic             periodEvent,
  output logic             unitLoadEvent,
  output logic             slaveCompareEvent,
  output logic [15:0]      activeStartDelay,
  output logic [15:0]      activeWidth,
  output logic [15:0]      activeCycleLength
);
  import prs_pkg::*;

  // ==========================================================
  // Register bus
  logic [7:0]  reloadControl;
  logic [7:0]  slaveSyncControl;
  logic [7:0]  unitMode;
  logic [15:0] startDelayValue;
  logic [15:0] activeWidthValue;
  logic [15:0] cycleLengthValue;
  logic [15:0] slaveTriggerValue;
  logic [15:0] activeSlaveTrigger;
  logic        activeMatchDirection;
  logic        countDown;
  prs_state_t  runState;
  logic        reloadNow;
  logic        trigSeen;
  logic        loadTrig;
  logic        offTrig;
  logic [2:0]  loadSync1, loadSync2, cmpSync1, cmpSync2;

  logic wrEn;
  logic rdHit;
  assign wrEn    = psel && penable && pwrite && clkEn;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rdHit;

  always_comb begin
    rdHit = 1'b1;
    unique case (paddr)
      `PRS_ADDR_RELOAD_CONTROL:     prdata = {24'h0000_00, reloadControl};
      `PRS_ADDR_SLAVE_SYNC_CONTROL: prdata = {24'h0000_00, slaveSyncControl};
      `PRS_ADDR_START_DELAY_HIGH:   prdata = {24'h0000_00, startDelayValue[15:8]};
      `PRS_ADDR_START_DELAY_LOW:    prdata = {24'h0000_00, startDelayValue[7:0]};
      `PRS_ADDR_ACTIVE_WIDTH_HIGH:  prdata = {24'h0000_00, activeWidthValue[15:8]};
      `PRS_ADDR_ACTIVE_WIDTH_LOW:   prdata = {24'h0000_00, activeWidthValue[7:0]};
      `PRS_ADDR_CYCLE_LENGTH_HIGH:  prdata = {24'h0000_00, cycleLengthValue[15:8]};
      `PRS_ADDR_CYCLE_LENGTH_LOW:   prdata = {24'h0000_00, cycleLengthValue[7:0]};
      `PRS_ADDR_SLAVE_TRIG_HIGH:    prdata = {24'h0000_00, slaveTriggerValue[15:8]};
      `PRS_ADDR_SLAVE_TRIG_LOW:     prdata = {24'h0000_00, slaveTriggerValue[7:0]};
      `PRS_ADDR_UNIT_MODE:          prdata = {24'h0000_00, unitMode};
      `PRS_ADDR_COUNTER_STATUS:     prdata = {14'h0000, runState, waveformCounter};
      default: begin
        prdata = 32'h0000_0000;
        rdHit  = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Value byte registers: no reset, contents survive resets
  always_ff @(posedge clk) begin
    if (wrEn) begin
      unique case (paddr)
        `PRS_ADDR_START_DELAY_HIGH:  startDelayValue[15:8]   <= pwdata[7:0];
        `PRS_ADDR_START_DELAY_LOW:   startDelayValue[7:0]    <= pwdata[7:0];
        `PRS_ADDR_ACTIVE_WIDTH_HIGH: activeWidthValue[15:8]  <= pwdata[7:0];
        `PRS_ADDR_ACTIVE_WIDTH_LOW:  activeWidthValue[7:0]   <= pwdata[7:0];
        `PRS_ADDR_CYCLE_LENGTH_HIGH: cycleLengthValue[15:8]  <= pwdata[7:0];
        `PRS_ADDR_CYCLE_LENGTH_LOW:  cycleLengthValue[7:0]   <= pwdata[7:0];
        `PRS_ADDR_SLAVE_TRIG_HIGH:   slaveTriggerValue[15:8] <= pwdata[7:0];
        `PRS_ADDR_SLAVE_TRIG_LOW:    slaveTriggerValue[7:0]  <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Control registers
  logic armWrite;
  assign armWrite = wrEn && (paddr == `PRS_ADDR_RELOAD_CONTROL);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reloadControl <= `PRS_RELOAD_CONTROL_RESET;
    end else if (clkEn) begin
      if (armWrite) begin
        reloadControl <= pwdata[7:0] & `PRS_RELOAD_CONTROL_MASK;
      end else if (reloadNow) begin
        reloadControl[`PRS_RELOAD_ARMED_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slaveSyncControl <= `PRS_SLAVE_SYNC_RESET;
      unitMode         <= `PRS_UNIT_MODE_RESET;
    end else if (wrEn) begin
      if (paddr == `PRS_ADDR_SLAVE_SYNC_CONTROL)
        slaveSyncControl <= pwdata[7:0] & `PRS_SLAVE_SYNC_MASK;
      if (paddr == `PRS_ADDR_UNIT_MODE)
        unitMode <= {6'h00, pwdata[1:0]};
    end
  end

  prs_slave_run_t slaveRun;
  prs_align_t     alignMode;
  logic           reloadArmed, reloadByTrigger;
  assign slaveRun        = prs_slave_run_t'(slaveSyncControl[6:5]);
  assign alignMode       = prs_align_t'(unitMode[1:0]);
  assign reloadArmed     = reloadControl[`PRS_RELOAD_ARMED_BIT];
  assign reloadByTrigger = reloadControl[`PRS_RELOAD_BY_TRIGGER_BIT];

  // ==========================================================
  // Sibling events come from other unit clocks, so two flops first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loadSync1 <= 3'h0;
      loadSync2 <= 3'h0;
      cmpSync1  <= 3'h0;
      cmpSync2  <= 3'h0;
    end else if (clkEn) begin
      loadSync1 <= siblingLoadEvent;
      loadSync2 <= loadSync1;
      cmpSync1  <= siblingCompareEvent;
      cmpSync2  <= cmpSync1;
    end
  end

  prs_trigger_select u_load_sel (
    .events    (loadSync2),
    .sourceSel (reloadControl[1:0]),
    .ownIndex  (OWN_INDEX),
    .picked    (loadTrig)
  );

  prs_trigger_select u_offset_sel (
    .events    (cmpSync2),
    .sourceSel (slaveSyncControl[1:0]),
    .ownIndex  (OWN_INDEX),
    .picked    (offTrig)
  );

  // ==========================================================
  // Reload arming
  logic armedLast;
  logic armQualified;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      armedLast <= 1'b0;
      trigSeen  <= 1'b0;
    end else if (clkEn) begin
      armedLast <= reloadArmed;
      if (reloadNow || !reloadArmed)
        trigSeen <= 1'b0;
      else if (reloadByTrigger && loadTrig)
        trigSeen <= 1'b1;
    end
  end

  // An arming that rises at the period event itself is held off one period
  assign armQualified = reloadArmed && armedLast;
  assign reloadNow    = periodEvent && armQualified &&
                        (!reloadByTrigger || trigSeen);
  assign unitLoadEvent = reloadNow;

  // All buffers move together at a reload only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      activeMatchDirection <= 1'b0;
    end else if (clkEn && reloadNow) begin
      activeMatchDirection <= slaveSyncControl[`PRS_MATCH_DIRECTION_BIT];
    end
  end

  // Operating buffers clear at reset so the counter never compares against unknowns
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      activeStartDelay   <= `PRS_OPERATING_RESET;
      activeWidth        <= `PRS_OPERATING_RESET;
      activeCycleLength  <= `PRS_OPERATING_RESET;
      activeSlaveTrigger <= `PRS_OPERATING_RESET;
    end else if (clkEn && reloadNow) begin
      activeStartDelay   <= startDelayValue;
      activeWidth        <= activeWidthValue;
      activeCycleLength  <= cycleLengthValue;
      activeSlaveTrigger <= slaveTriggerValue;
    end
  end

  // ==========================================================
  // Slave run control and counter
  logic counting;
  assign counting = (runState == PRS_ST_RUN);
  assign periodEvent = counting && (alignMode == PRS_MODE_CENTER ?
                       (countDown && waveformCounter == 16'h0000) :
                       (waveformCounter == activeCycleLength));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      runState <= PRS_ST_IDLE;
    end else if (clkEn) begin
      unique case (runState)
        PRS_ST_IDLE:
          runState <= (slaveRun == PRS_RUN_INDEPENDENT) ? PRS_ST_RUN : PRS_ST_WAIT;
        PRS_ST_WAIT:
          if (slaveRun == PRS_RUN_INDEPENDENT)
            runState <= PRS_ST_RUN;
          else if (offTrig)
            runState <= PRS_ST_RUN;
        PRS_ST_RUN:
          if (periodEvent && slaveRun == PRS_RUN_ONE_SHOT)
            runState <= PRS_ST_DONE;
        PRS_ST_DONE:
          if (slaveRun != PRS_RUN_ONE_SHOT)
            runState <= PRS_ST_IDLE;
          else if (offTrig)
            runState <= PRS_ST_RUN;
      endcase
    end
  end

  logic restart;
  assign restart = (runState != PRS_ST_RUN && offTrig) ||
                   (counting && slaveRun == PRS_RUN_CONTINUOUS && offTrig);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waveformCounter <= 16'h0000;
      countDown       <= 1'b0;
    end else if (clkEn) begin
      if (restart) begin
        waveformCounter <= 16'h0000;
        countDown       <= 1'b0;
      end else if (counting) begin
        if (alignMode != PRS_MODE_CENTER) begin
          countDown       <= 1'b0;
          waveformCounter <= periodEvent ? 16'h0000 : waveformCounter + 16'h0001;
        end else if (!countDown) begin
          if (waveformCounter >= activeCycleLength)
            countDown <= 1'b1;
          else
            waveformCounter <= waveformCounter + 16'h0001;
        end else if (waveformCounter == 16'h0000) begin
          countDown <= 1'b0;
        end else begin
          waveformCounter <= waveformCounter - 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // Offset match pulse
  logic offsetHit;
  always_comb begin
    offsetHit = counting && (waveformCounter == activeSlaveTrigger);
    if (alignMode == PRS_MODE_CENTER)
      offsetHit = offsetHit && (countDown == activeMatchDirection);
    // Other modes take the match as is
  end

  logic offsetHitLast;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      offsetHitLast <= 1'b0;
    end else if (clkEn) begin
      offsetHitLast <= offsetHit;
    end
  end
  // Edge only, so a counter held at the apex still gives one pulse
  assign slaveCompareEvent = offsetHit && !offsetHitLast && clkEn;

  // ==========================================================
  // Checks
  sequence s_armed_then_period;
    clkEn && armQualified && !reloadByTrigger ##0 periodEvent;
  endsequence

  immediate_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_armed_then_period |-> unitLoadEvent ##1 !reloadArmed)
    else $error("immediate reload missed");
  no_trigger_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
    reloadByTrigger && !trigSeen |-> !unitLoadEvent)
    else $error("triggered reload without trigger");
  late_arm_a: assert property (@(posedge clk) disable iff (sys_rst)
    reloadArmed && !armedLast |-> !unitLoadEvent)
    else $error("arming honoured in its first cycle");
  buffer_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !unitLoadEvent |=> $stable(activeCycleLength))
    else $error("active period moved without reload");
  direction_buf_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && unitLoadEvent |=> activeMatchDirection == $past(slaveSyncControl[4]))
    else $error("match direction not taken at reload");
  reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    (reloadControl & 8'h3C) == 8'h00 && (slaveSyncControl & 8'h8C) == 8'h00)
    else $error("unimplemented bit set");
  continuous_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && counting && slaveRun == PRS_RUN_CONTINUOUS && offTrig |=> waveformCounter == 16'h0000)
    else $error("continuous slave did not restart");
  center_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
    slaveCompareEvent && alignMode == PRS_MODE_CENTER |-> countDown == activeMatchDirection)
    else $error("offset match on wrong slope");
  one_shot_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && periodEvent && slaveRun == PRS_RUN_ONE_SHOT |=> runState == PRS_ST_DONE)
    else $error("one-shot did not stop");
  own_reserved_a: assert property (@(posedge clk) disable iff (sys_rst)
    reloadControl[1:0] == OWN_INDEX || reloadControl[1:0] == 2'b00 |-> !loadTrig)
    else $error("own or reserved load source fired");
endmodule : prs_unit
`default_nettype wire

//--- tb/prs_sibling_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Sibling units: emit load and offset-match pulses on request
// ============================================================
module prs_sibling_model (
  input  wire logic       clk,
  output logic      [2:0] loadEvent,
  output logic      [2:0] compareEvent
);
  initial begin
    loadEvent    = 3'h0;
    compareEvent = 3'h0;
  end

  // One clock wide, launched just after an edge, like a real unit's pulse
  task automatic pulse(input logic isLoad, input logic [2:0] which);
    @(posedge clk);
    if (isLoad) loadEvent <= which;
    else compareEvent <= which;
    @(posedge clk);
    loadEvent    <= 3'h0;
    compareEvent <= 3'h0;
  endtask : pulse
endmodule : prs_sibling_model
`default_nettype wire

//--- tb/tb_pwm_reload_offset_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "prs_cfg.svh"
module tb_pwm_reload_offset_sync;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} prs_row_t;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, seen;
  logic [2:0]  sibLoad, sibCmp;
  logic [15:0] waveformCounter, activeStartDelay, activeWidth, activeCycleLength;
  logic        periodEvent, unitLoadEvent, slaveCompareEvent;
  int          num_errors = 0, check_count = 0, cycles = 0;
  prs_row_t    rows[11];

  always #2.5 clk = ~clk;

  prs_unit #(.OWN_INDEX(2'd1)) i_prs_unit (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .siblingLoadEvent(sibLoad),
    .siblingCompareEvent(sibCmp), .waveformCounter(waveformCounter),
    .periodEvent(periodEvent), .unitLoadEvent(unitLoadEvent),
    .slaveCompareEvent(slaveCompareEvent), .activeStartDelay(activeStartDelay),
    .activeWidth(activeWidth), .activeCycleLength(activeCycleLength));
  prs_sibling_model i_prs_sibling_model (.clk(clk), .loadEvent(sibLoad), .compareEvent(sibCmp));

  // ============================================================
  // Compare, bus and observation tasks
  // ============================================================
  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h00_0000, d}, rd, err);
  endtask : wr

  // Watches for a buffer transfer, stops at the first one seen
  task automatic wait_load(input int n, output logic s);
    s = 1'b0;
    for (int i = 0; i < n && !s; i++) begin
      @(negedge clk);
      if (unitLoadEvent === 1'b1) s = 1'b1;
    end
  endtask : wait_load

  // Watches for an offset-match pulse, stops at the first one seen
  task automatic wait_cmp(input int n, output logic s);
    s = 1'b0;
    for (int i = 0; i < n && !s; i++) begin
      @(negedge clk);
      if (slaveCompareEvent === 1'b1) s = 1'b1;
    end
  endtask : wait_cmp

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Whole sequence needs under two thousand cycles; a hang ends here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    rows = '{
      '{`PRS_ADDR_RELOAD_CONTROL,     32'h0000_007F, 32'h0000_0043, 1'b0},
      '{`PRS_ADDR_SLAVE_SYNC_CONTROL, 32'h0000_008C, 32'h0000_0000, 1'b0},
      '{`PRS_ADDR_SLAVE_SYNC_CONTROL, 32'h0000_0013, 32'h0000_0013, 1'b0},
      '{`PRS_ADDR_START_DELAY_HIGH,   32'h0000_00A5, 32'h0000_00A5, 1'b0},
      '{`PRS_ADDR_START_DELAY_LOW,    32'h0000_005A, 32'h0000_005A, 1'b0},
      '{`PRS_ADDR_ACTIVE_WIDTH_HIGH,  32'h0000_0000, 32'h0000_0000, 1'b0},
      '{`PRS_ADDR_ACTIVE_WIDTH_LOW,   32'h0000_0008, 32'h0000_0008, 1'b0},
      '{`PRS_ADDR_CYCLE_LENGTH_HIGH,  32'h0000_0000, 32'h0000_0000, 1'b0},
      '{`PRS_ADDR_CYCLE_LENGTH_LOW,   32'h0000_0010, 32'h0000_0010, 1'b0},
      '{`PRS_ADDR_SLAVE_TRIG_HIGH,    32'h0000_0012, 32'h0000_0012, 1'b0},
      '{12'h030,                      32'h0000_00FF, 32'h0000_0000, 1'b1}};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    apb(`PRS_ADDR_RELOAD_CONTROL, 1'b0, 32'h0, rd, err);
    chk_val("reload_control reset", {24'h0, `PRS_RELOAD_CONTROL_RESET}, rd);
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].w, rd, err);
      chk_bit("write error", rows[i].e, err);
      apb(rows[i].a, 1'b0, 32'h0, rd, err);
      chk_val("readback", rows[i].r, rd);
    end
    // Value bytes survive a warm reset, control bytes clear
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    apb(`PRS_ADDR_START_DELAY_HIGH, 1'b0, 32'h0, rd, err);
    chk_val("delay kept", 32'h0000_00A5, rd);
    apb(`PRS_ADDR_SLAVE_SYNC_CONTROL, 1'b0, 32'h0, rd, err);
    chk_val("sync reset", {24'h0, `PRS_SLAVE_SYNC_RESET}, rd);
    // Immediate reload with a source code that must be ignored
    wr(`PRS_ADDR_RELOAD_CONTROL, 8'h83);
    wait_load(100, seen);
    chk_bit("immediate load", 1'b1, seen);
    @(negedge clk);
    chk_val("period buf", 32'h0000_0010, {16'h0, activeCycleLength});
    chk_val("phase buf", 32'h0000_A55A, {16'h0, activeStartDelay});
    chk_val("duty buf", 32'h0000_0008, {16'h0, activeWidth});
    apb(`PRS_ADDR_RELOAD_CONTROL, 1'b0, 32'h0, rd, err);
    chk_val("armed cleared", 32'h0000_0003, rd);
    // A staged value stays out of the operating buffer without arming
    wr(`PRS_ADDR_CYCLE_LENGTH_LOW, 8'h20);
    repeat (60) @(negedge clk);
    chk_val("staged only", 32'h0000_0010, {16'h0, activeCycleLength});
    // Triggered reload for every source code; own unit is number one
    for (int s = 0; s < 4; s++) begin
      wr(`PRS_ADDR_CYCLE_LENGTH_LOW, 8'h18 + 8'(s));
      wr(`PRS_ADDR_RELOAD_CONTROL, {6'b110000, 2'(s)});
      wait_load(60, seen);
      chk_bit("load without trigger", 1'b0, seen);
      i_prs_sibling_model.pulse(1'b1, (s == 0) ? 3'b111 : 3'(1 << (s - 1)));
      wait_load(90, seen);
      chk_bit("triggered load", s >= 2, seen);
      if (s >= 2) begin
        chk_bit("period at load", 1'b1, periodEvent);
        @(negedge clk);
        chk_val("trig period buf", 32'h18 + s, {16'h0, activeCycleLength});
      end
      wr(`PRS_ADDR_RELOAD_CONTROL, 8'h00);
    end
    // Cancelled arming ignores a later trigger
    wr(`PRS_ADDR_RELOAD_CONTROL, 8'hC2);
    wr(`PRS_ADDR_RELOAD_CONTROL, 8'h42);
    i_prs_sibling_model.pulse(1'b1, 3'b010);
    wait_load(90, seen);
    chk_bit("cancelled load", 1'b0, seen);
    // Continuous slave restarts its count on the selected offset trigger
    wr(`PRS_ADDR_SLAVE_SYNC_CONTROL, 8'h62);
    repeat (10) @(posedge clk);
    i_prs_sibling_model.pulse(1'b0, 3'b010);
    repeat (4) @(negedge clk);
    chk_val("counter restart", 32'h0000_0001, {16'h0, waveformCounter});
    // Offset match: standard mode ignores the direction bit, center mode obeys it
    wr(`PRS_ADDR_SLAVE_TRIG_HIGH, 8'h00);
    wr(`PRS_ADDR_SLAVE_TRIG_LOW, 8'h05);
    for (int m = 0; m < 3; m++) begin
      if (m == 1) wr(`PRS_ADDR_UNIT_MODE, 8'h03);
      wr(`PRS_ADDR_SLAVE_SYNC_CONTROL, (m == 2) ? 8'h00 : 8'h10);
      wr(`PRS_ADDR_RELOAD_CONTROL, 8'h80);
      wait_load(120, seen);
      chk_bit("armed reload", 1'b1, seen);
      wait_cmp(120, seen);
      chk_bit("offset match", 1'b1, seen);
      @(negedge clk);
      chk_val("count after match", (m == 1) ? 32'h0000_0004 : 32'h0000_0006,
              {16'h0, waveformCounter});
    end
    // One-shot slave stops at its period end and reruns on the next offset trigger
    wr(`PRS_ADDR_UNIT_MODE, 8'h00);
    wr(`PRS_ADDR_SLAVE_SYNC_CONTROL, 8'h42);
    repeat (80) @(negedge clk);
    apb(`PRS_ADDR_COUNTER_STATUS, 1'b0, 32'h0, rd, err);
    chk_val("one-shot stopped", 32'h0002_0000, rd);
    i_prs_sibling_model.pulse(1'b0, 3'b010);
    repeat (4) @(negedge clk);
    chk_val("one-shot rerun", 32'h0000_0001, {16'h0, waveformCounter});
    tally_and_finish();
  end
endmodule : tb_pwm_reload_offset_sync
`default_nettype wire
